// [hw/sep_cmd_protect.sv]
// Purpose: opcode decode, write latch, busy flag and write protection of an SPI EEPROM
// Assumes: link logic on the serial clock; chip select high at least 4 system clocks
// Notes: array data paths are outside; a memory write is handed off as a pulse
`timescale 1ns/10ps
module sep_cmd_protect #(
    parameter int unsigned ADDR_BITS    = 13,
    parameter int unsigned WRITE_CYCLES = sep_pkg::WRITE_CYCLES
) (
    // system
    input  wire logic        clk_sys_i,
    input  wire logic        rst_i,
    // serial link
    input  wire logic        spi_clk_i,
    input  wire logic        spi_cs_n_i,
    input  wire logic        spi_mosi_i,
    output logic             spi_miso_o,
    output logic             spi_miso_oe_o,
    // protect pin
    input  wire logic        wp_n_i,
    // memory write hand-off
    output logic             mem_wr_go_o,
    output logic [15:0]      mem_wr_addr_o,
    // visibility
    output logic [7:0]       status_o,
    output logic             hw_protect_o
);

    // ---------------- link domain ----------------
    logic             link_rst;
    logic             start_q;
    logic [2:0]       bitc_q;
    logic [2:0]       bytec_q;
    logic [7:0]       sh_q;
    logic [7:0]       op_q;
    logic [7:0]       byte1_q;
    logic [7:0]       byte2_q;
    logic             tgl_q;
    logic [7:0]       stat_l1_q;
    logic [7:0]       stat_l2_q;
    logic [7:0]       stat_l3_q;
    logic [7:0]       stat_hold_q;
    logic [7:0]       osh_q;
    logic             rd_go;
    logic [7:0]       byte_in;

    assign link_rst = rst_i | spi_cs_n_i;
    assign byte_in  = {sh_q[6:0], spi_mosi_i};

    // marks the first rising edge of a frame
    always_ff @(posedge spi_clk_i or posedge link_rst) begin
        if (link_rst) begin
            start_q <= 1'b1;
        end else begin
            start_q <= 1'b0;
        end
    end

    // frame counters hold after deselect so the system side can judge the frame
    always_ff @(posedge spi_clk_i or posedge rst_i) begin
        if (rst_i) begin
            bitc_q  <= 3'h0;
            bytec_q <= 3'h0;
            sh_q    <= 8'h00;
            tgl_q   <= 1'b0;
        end else if (start_q && !spi_cs_n_i) begin
            bitc_q  <= 3'h1;
            bytec_q <= 3'h0;
            sh_q    <= {7'h00, spi_mosi_i};
            tgl_q   <= ~tgl_q;
        end else if (!start_q) begin
            // edges while deselected (idle level change) are ignored
            bitc_q  <= bitc_q + 3'h1;
            sh_q    <= byte_in;
            if (bitc_q == 3'h7 && bytec_q != 3'h7) begin
                bytec_q <= bytec_q + 3'h1;
            end
        end
    end

    // byte capture: opcode, then address or status data
    always_ff @(posedge spi_clk_i or posedge rst_i) begin
        if (rst_i) begin
            op_q    <= 8'h00;
            byte1_q <= 8'h00;
            byte2_q <= 8'h00;
        end else if (!start_q && bitc_q == 3'h7) begin
            unique case (bytec_q)
                3'h0:    op_q    <= byte_in;
                3'h1:    byte1_q <= byte_in;
                3'h2:    byte2_q <= byte_in;
                default: ;
            endcase
        end
    end

    // status copy into the link domain
    always_ff @(negedge spi_clk_i or posedge rst_i) begin
        if (rst_i) begin
            stat_l1_q   <= 8'h00;
            stat_l2_q   <= 8'h00;
            stat_l3_q   <= 8'h00;
            stat_hold_q <= 8'h00;
        end else begin
            stat_l1_q <= status_o;
            stat_l2_q <= stat_l1_q;
            stat_l3_q <= stat_l2_q;
            // taken only when two samples agree, so no torn word is sent
            if (stat_l2_q == stat_l3_q) begin
                stat_hold_q <= stat_l3_q;
            end
        end
    end

    // unknown opcodes never reach rd_go, so the output stays off
    assign rd_go = !start_q && bytec_q != 3'h0 && op_q == sep_pkg::status_read_cmd;

    // status shift-out on falling edges, reloaded every byte
    always_ff @(negedge spi_clk_i or posedge link_rst) begin
        if (link_rst) begin
            spi_miso_o    <= 1'b0;
            spi_miso_oe_o <= 1'b0;
            osh_q         <= 8'h00;
        end else if (rd_go) begin
            spi_miso_oe_o <= 1'b1;
            if (bitc_q == 3'h0) begin
                osh_q      <= stat_hold_q;
                spi_miso_o <= stat_hold_q[7];
            end else begin
                osh_q      <= {osh_q[6:0], 1'b0};
                spi_miso_o <= osh_q[6];
            end
        end
    end

    // ---------------- system domain ----------------
    logic [2:0]               cs_s_q;
    logic [2:0]               wp_s_q;
    logic [2:0]               tg_s_q;
    logic                     cs_hi_q;
    logic                     wp_hi_q;
    logic                     tg_lvl_q;
    logic                     seen_q;
    logic                     eval;
    logic                     hw_prot;
    logic                     busy;
    logic                     done;
    logic                     prot;
    logic                     whole;
    logic                     en_ok;
    logic                     dis_ok;
    logic                     stwr_ok;
    logic                     write_ok;
    logic [15:0]              addr;
    logic [31:0]              timer_q;
    sep_pkg::sep_state_e      state_q;
    logic                     latch_q;
    logic [1:0]               bp_q;
    logic                     lock_q;
    logic                     pend_q;
    logic [2:0]               pend_val_q;

    // three-stage synchronisers; level moves when stages 2 and 3 agree
    always_ff @(posedge clk_sys_i or posedge rst_i) begin
        if (rst_i) begin
            cs_s_q   <= 3'b111;
            wp_s_q   <= 3'b111;
            tg_s_q   <= 3'b000;
            cs_hi_q  <= 1'b1;
            wp_hi_q  <= 1'b1;
            tg_lvl_q <= 1'b0;
        end else begin
            cs_s_q <= {cs_s_q[1:0], spi_cs_n_i};
            wp_s_q <= {wp_s_q[1:0], wp_n_i};
            tg_s_q <= {tg_s_q[1:0], tgl_q};
            if (cs_s_q[1] == cs_s_q[2]) begin
                cs_hi_q <= cs_s_q[2];
            end
            if (wp_s_q[1] == wp_s_q[2]) begin
                wp_hi_q <= wp_s_q[2];
            end
            if (tg_s_q[1] == tg_s_q[2]) begin
                tg_lvl_q <= tg_s_q[2];
            end
        end
    end

    // a frame is judged once, at its deselect
    assign eval  = cs_s_q[1] & cs_s_q[2] & ~cs_hi_q & (tg_lvl_q != seen_q);
    assign hw_prot = lock_q & ~wp_hi_q;
    assign busy  = (state_q == sep_pkg::ST_BUSY);
    assign done  = busy && (timer_q == WRITE_CYCLES - 1);
    assign addr  = {byte1_q, byte2_q};
    assign prot  = sep_pkg::sep_in_protect(addr, bp_q, ADDR_BITS);
    assign whole = (bitc_q == 3'h0);

    assign en_ok    = op_q == sep_pkg::write_enable_cmd  && whole
                      && bytec_q == sep_pkg::BYTES_CMD;
    assign dis_ok   = op_q == sep_pkg::write_disable_cmd && whole
                      && bytec_q == sep_pkg::BYTES_CMD;
    assign stwr_ok  = op_q == sep_pkg::status_write_cmd  && whole
                      && bytec_q == sep_pkg::BYTES_STWR && latch_q
                      && !hw_prot && !busy;
    assign write_ok = op_q == sep_pkg::array_write_cmd   && whole
                      && bytec_q >= sep_pkg::BYTES_WRITE && latch_q
                      && !busy && !prot;

    always_ff @(posedge clk_sys_i or posedge rst_i) begin
        if (rst_i) begin
            seen_q <= 1'b0;
        end else if (eval) begin
            seen_q <= tg_lvl_q;
        end
    end

    // self-timed cycle, started at deselect
    always_ff @(posedge clk_sys_i or posedge rst_i) begin
        if (rst_i) begin
            state_q <= sep_pkg::ST_IDLE;
            timer_q <= 32'h0000_0000;
        end else begin
            unique case (state_q)
                sep_pkg::ST_IDLE: begin
                    timer_q <= 32'h0000_0000;
                    if (eval && (stwr_ok || write_ok)) begin
                        state_q <= sep_pkg::ST_BUSY;
                    end
                end
                sep_pkg::ST_BUSY: begin
                    timer_q <= timer_q + 32'h0000_0001;
                    if (done) begin
                        state_q <= sep_pkg::ST_IDLE;
                    end
                end
            endcase
        end
    end

    // write latch; a write-enable in the completion cycle wins
    always_ff @(posedge clk_sys_i or posedge rst_i) begin
        if (rst_i) begin
            latch_q <= 1'b0;
        end else begin
            if (done || (eval && dis_ok)) begin
                latch_q <= 1'b0;
            end
            if (eval && en_ok) begin
                latch_q <= 1'b1;
            end
        end
    end

    // non-volatile bits keep their value until the cycle completes
    always_ff @(posedge clk_sys_i or posedge rst_i) begin
        if (rst_i) begin
            pend_q     <= 1'b0;
            pend_val_q <= 3'h0;
            lock_q     <= sep_pkg::NV_RST[2];
            bp_q       <= sep_pkg::NV_RST[1:0];
        end else if (eval && stwr_ok) begin
            pend_q     <= 1'b1;
            pend_val_q <= {byte1_q[sep_pkg::LOCK_BIT], byte1_q[sep_pkg::BP_HI_BIT],
                           byte1_q[sep_pkg::BP_LO_BIT]};
        end else if (done && pend_q) begin
            pend_q <= 1'b0;
            lock_q <= pend_val_q[2];
            bp_q   <= pend_val_q[1:0];
        end
    end

    // registered outputs
    always_ff @(posedge clk_sys_i or posedge rst_i) begin
        if (rst_i) begin
            status_o      <= 8'h00;
            hw_protect_o  <= 1'b0;
            mem_wr_go_o   <= 1'b0;
            mem_wr_addr_o <= 16'h0000;
        end else begin
            status_o <= {lock_q, 3'b000, bp_q, latch_q, busy};
            hw_protect_o <= hw_prot;
            mem_wr_go_o  <= eval && write_ok;
            if (eval && write_ok) begin
                mem_wr_addr_o <= addr;
            end
        end
    end

    // ---------------- checks ----------------
    default clocking cb_sys @(posedge clk_sys_i); endclocking
    default disable iff (rst_i);

    a_busy_bounded: assert property (busy |-> timer_q < WRITE_CYCLES)
        else $error("busy cycle overran its length");
    a_end_clears_latch: assert property (
        (done && !(eval && en_ok)) |=> !latch_q && !busy)
        else $error("write latch survived cycle completion");
    a_need_latch: assert property ((eval && !latch_q && !busy) |=> !busy)
        else $error("write started without write latch");
    a_odd_clocks: assert property ((eval && bitc_q != 3'h0 && !busy) |=> !busy)
        else $error("frame with partial byte was executed");
    a_enable_sets: assert property (
        (eval && en_ok) |=> latch_q ##1 status_o[sep_pkg::LATCH_BIT])
        else $error("write enable did not set the latch");
    a_disable_clears: assert property ((eval && dis_ok) |=> !latch_q)
        else $error("write disable did not clear the latch");
    a_hwp_freeze: assert property (
        (hw_prot && !pend_q) |=> $stable(lock_q) && $stable(bp_q))
        else $error("protected status bits changed in hardware protect");
    a_prot_refuse: assert property (
        (eval && op_q == sep_pkg::array_write_cmd && prot && !busy) |=> !mem_wr_go_o && !busy)
        else $error("write into protected block accepted");
    a_unknown_ignored: assert property (
        (eval && !sep_pkg::sep_known_op(op_q) && !busy) |=> !busy && $stable(latch_q))
        else $error("unknown opcode frame had an effect");
    a_go_busy: assert property (mem_wr_go_o |-> busy ##1 status_o[sep_pkg::BUSY_BIT])
        else $error("memory write without busy flag");
    a_idle_miso: assert property ((cs_hi_q && $past(cs_hi_q)) |-> !spi_miso_oe_o)
        else $error("output driven while deselected");

endmodule : sep_cmd_protect

// [hw/sep_pkg.sv]
// Purpose: constants, status layout and decode helpers for the SPI EEPROM command block
// Assumes: 20 MHz system clock, serial link in mode 0 or mode 3
// Notes on behaviour
// - memory and status writes execute only when frame clock count is a multiple of eight.
// - memory and status writes need a prior write-enable that set the write latch.
// - write latch clears at reset, write-disable, status-write end and memory-write end.
// - chip select must rise after the last bit's rising edge, before the next one.
// - last bit is opcode or data byte eighth bit; reads skip this check.
// - protect 00 none, 01 upper quarter, 10 upper half, 11 whole; large part 1FFFh top.
// - small part ranges end at 0FFFh, starting 0C00h, 0800h or 0000h.
// - opcodes 06h write enable, 04h write disable, 05h status read.
// - opcodes 01h status write, 03h array read, 02h array write.
// - an unknown opcode makes the device ignore the frame until next select.
// - only write-enable sets the latch; it then idles until deselect.
// - write-disable clears the latch; it then idles until deselect.
// - status may be read anytime, also while busy and repeatedly in one frame.
// - busy flag is 1 during a write or status-write cycle, else 0.
// - write latch bit mirrors the latch; at 0 no write is accepted.
// - protect bits are written only by status-write, and not in hardware protect mode.
// - memory writes into the protected area are refused.
// - lock bit 1 and protect pin low gives hardware protect; status-write rejected.
// - status-write leaves bits 6,5,4,1,0; bits 6 to 4 read zero.
// - status-write cycle starts at deselect; busy throughout; latch cleared at end.
package sep_pkg;

    // opcodes
    localparam logic [7:0] write_enable_cmd  = 8'h06;
    localparam logic [7:0] write_disable_cmd = 8'h04;
    localparam logic [7:0] status_read_cmd   = 8'h05;
    localparam logic [7:0] status_write_cmd  = 8'h01;
    localparam logic [7:0] array_read_cmd    = 8'h03;
    localparam logic [7:0] array_write_cmd   = 8'h02;

    // status register bit positions
    localparam int unsigned BUSY_BIT    = 0;
    localparam int unsigned LATCH_BIT   = 1;
    localparam int unsigned BP_LO_BIT   = 2;
    localparam int unsigned BP_HI_BIT   = 3;
    localparam int unsigned LOCK_BIT    = 7;

    // non-volatile bits after reset (lock, protect hi, protect lo)
    localparam logic [2:0] NV_RST       = 3'h0;

    // whole bytes a frame needs
    localparam logic [2:0] BYTES_CMD    = 3'h1;
    localparam logic [2:0] BYTES_STWR   = 3'h2;
    localparam logic [2:0] BYTES_WRITE  = 3'h4;

    // self-timed write cycle
    localparam int unsigned CLK_KHZ      = 20000;
    localparam int unsigned T_WRITE_MS   = 5;
    localparam int unsigned WRITE_CYCLES = T_WRITE_MS * CLK_KHZ;

    typedef enum logic {ST_IDLE, ST_BUSY} sep_state_e;

    function automatic logic sep_known_op(input logic [7:0] op);
        sep_known_op = (op == write_enable_cmd) || (op == write_disable_cmd) ||
                       (op == status_read_cmd)  || (op == status_write_cmd)  ||
                       (op == array_read_cmd)   || (op == array_write_cmd);
    endfunction : sep_known_op

    // address inside the block chosen by the protect bits; aw is address width
    function automatic logic sep_in_protect(input logic [15:0] addr,
                                            input logic [1:0]  bp,
                                            input int unsigned aw);
        unique case (bp)
            2'b00:   sep_in_protect = 1'b0;
            2'b01:   sep_in_protect = addr[aw-1] & addr[aw-2];
            2'b10:   sep_in_protect = addr[aw-1];
            default: sep_in_protect = 1'b1;
        endcase
    endfunction : sep_in_protect

endpackage : sep_pkg

// [verif/sep_spi_master.sv]
// Purpose: mode 0 or mode 3 serial bus master driving frames into the command block
// Assumes: link clock period 125 ns, idle level set by mode3, still outside frames
// Notes: mosi shows the inverse of its last bit once a frame ends
`timescale 1ns/10ps
module sep_spi_master (
    // serial link
    output logic            spi_clk_o,
    output logic            spi_cs_n_o,
    output logic            spi_mosi_o,
    input  wire logic       spi_miso_i
);
    // clock idles high when set
    logic mode3 = 1'b0;

    initial begin
        spi_clk_o  = 1'b0;
        spi_cs_n_o = 1'b1;
        spi_mosi_o = 1'b0;
    end

    // bits go out from d[31] down; rx keeps the last 16 bits sampled
    task automatic frame(input logic [31:0] d, input int nbits, output logic [15:0] rx);
        rx = 16'h0000;
        spi_clk_o = mode3;
        #(62.5);
        spi_cs_n_o = 1'b0;
        #(62.5);
        for (int i = 0; i < nbits; i++) begin
            if (mode3) begin
                spi_clk_o = 1'b0;
            end
            spi_mosi_o = d[31-i];
            #(62.5);
            spi_clk_o = 1'b1;
            rx = {rx[14:0], spi_miso_i};
            #(31.25);
            // deselect between last rising edge and the next one
            if (i == nbits - 1) begin
                spi_cs_n_o = 1'b1;
            end
            #(31.25);
            if (!mode3) begin
                spi_clk_o = 1'b0;
            end
        end
        spi_mosi_o = ~spi_mosi_o;
        // deselect gap well above 200 ns
        #(300);
    endtask : frame
endmodule : sep_spi_master

// [verif/sep_cmd_protect_test.sv]
// Purpose: self-checking bench for the command and protection block
// Assumes: short write cycle of 80 system clocks, large part address width
// Notes: frames come from the bus master model, checks look at status_o, rx, hw_protect_o, oe_cnt and the hand-off pulses
`timescale 1ns/10ps
module sep_cmd_protect_test;
    localparam int unsigned WC = 80;
    logic        clk_sys_i = 1'b0;
    logic        rst_i     = 1'b1;
    logic        wp_n_i    = 1'b1;
    logic        spi_clk_i;
    logic        spi_cs_n_i;
    logic        spi_mosi_i;
    logic        spi_miso_o;
    logic        spi_miso_oe_o;
    logic        mem_wr_go_o;
    logic        hw_protect_o;
    logic [15:0] mem_wr_addr_o;
    logic [15:0] rx;
    logic [15:0] last_addr = 16'h0000;
    logic [7:0]  status_o;
    logic [7:0]  bp_val;
    int          err_total   = 0;
    int          checks_done = 0;
    int          go_cnt      = 0;
    int          oe_cnt      = 0;
    logic        miso_bus;
    int          n;
    logic [1:0]  tb_bp [6]  = '{2'h0, 2'h1, 2'h1, 2'h2, 2'h2, 2'h3};
    logic [15:0] tb_adr [6] = '{16'h1FFF, 16'h17FF, 16'h1800, 16'h0FFF, 16'h1000, 16'h0000};
    logic        tb_ok [6]  = '{1'b1, 1'b1, 1'b0, 1'b1, 1'b0, 1'b0};

    always #25 clk_sys_i = ~clk_sys_i;

    // released line shows the inverse of spi_miso_o, which is 0 whenever released, so it reads high
    assign miso_bus = spi_miso_oe_o ? spi_miso_o : ~spi_miso_o;

    sep_cmd_protect #(.ADDR_BITS(13), .WRITE_CYCLES(WC)) sep_cmd_protect_i (
        .clk_sys_i(clk_sys_i), .rst_i(rst_i), .spi_clk_i(spi_clk_i),
        .spi_cs_n_i(spi_cs_n_i), .spi_mosi_i(spi_mosi_i), .spi_miso_o(spi_miso_o),
        .spi_miso_oe_o(spi_miso_oe_o), .wp_n_i(wp_n_i), .mem_wr_go_o(mem_wr_go_o),
        .mem_wr_addr_o(mem_wr_addr_o), .status_o(status_o), .hw_protect_o(hw_protect_o)
    );

    sep_spi_master sep_spi_master_i (
        .spi_clk_o(spi_clk_i), .spi_cs_n_o(spi_cs_n_i),
        .spi_mosi_o(spi_mosi_i), .spi_miso_i(miso_bus)
    );

    always @(posedge clk_sys_i) begin
        if (mem_wr_go_o === 1'b1) begin
            go_cnt    <= go_cnt + 1;
            last_addr <= mem_wr_addr_o;
        end
    end

    // link rising edges at which the device drives its output
    always @(posedge spi_clk_i) begin
        if (spi_miso_oe_o === 1'b1) begin
            oe_cnt <= oe_cnt + 1;
        end
    end

    task automatic chk(input logic [15:0] got, input logic [15:0] exp);
        checks_done++;
        if (got !== exp) begin
            err_total++;
            $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask : chk

    task automatic wait_st(input logic [7:0] exp);
        for (int i = 0; i < 400 && status_o !== exp; i++) @(negedge clk_sys_i);
        chk({8'h00, status_o}, {8'h00, exp});
    endtask : wait_st

    task automatic cmd(input logic [31:0] d, input int nbits);
        sep_spi_master_i.frame(d, nbits, rx);
        repeat (10) @(negedge clk_sys_i);
    endtask : cmd

    task automatic set_latch();
        cmd({sep_pkg::write_enable_cmd, 24'h00_0000}, 8);
    endtask : set_latch

    task automatic print_verdict();
        $display("errors %0d checks %0d", err_total, checks_done);
        if (err_total == 0 && checks_done > 0) begin
            $display("TB: PASS");
        end else begin
            $display("TB: FAIL");
        end
        $finish;
    endtask : print_verdict

    initial begin
        #(3_000_000);
        err_total++;
        print_verdict();
    end

    initial begin
        repeat (20) @(negedge clk_sys_i);
        rst_i = 1'b0;
        repeat (4) @(negedge clk_sys_i);
        chk({8'h00, status_o}, 16'h0000);
        chk({15'h0000, hw_protect_o}, 16'h0000);
        cmd({sep_pkg::status_write_cmd, 8'hFF, 16'h0000}, 16);
        chk({8'h00, status_o}, 16'h0000);
        set_latch();
        chk({8'h00, status_o}, 16'h0002);
        n = oe_cnt;
        cmd({sep_pkg::status_read_cmd, 24'h00_0000}, 24);
        chk(rx, 16'h0202);
        chk(oe_cnt[15:0], n[15:0] + 16'h0010);
        sep_spi_master_i.mode3 = 1'b1;
        cmd({sep_pkg::status_read_cmd, 24'h00_0000}, 24);
        chk(rx, 16'h0202);
        sep_spi_master_i.mode3 = 1'b0;
        n = oe_cnt;
        cmd({8'hAB, sep_pkg::write_disable_cmd, 16'h0000}, 16);
        chk({8'h00, status_o}, 16'h0002);
        chk(oe_cnt[15:0], n[15:0]);
        cmd({sep_pkg::write_disable_cmd, 24'h00_0000}, 8);
        chk({8'h00, status_o}, 16'h0000);
        set_latch();
        cmd({sep_pkg::status_write_cmd, 8'hFF, 16'h0000}, 15);
        chk({8'h00, status_o}, 16'h0002);
        cmd({sep_pkg::status_write_cmd, 8'hFF, 16'h0000}, 17);
        chk({8'h00, status_o}, 16'h0002);
        cmd({sep_pkg::status_write_cmd, 8'hFF, 16'h0000}, 16);
        chk({8'h00, status_o}, 16'h0003);
        cmd({sep_pkg::status_read_cmd, 24'h00_0000}, 16);
        chk({8'h00, rx[7:0]}, 16'h0003);
        wait_st(8'h8C);
        @(negedge clk_sys_i);
        wp_n_i = 1'b0;
        repeat (6) @(negedge clk_sys_i);
        chk({15'h0000, hw_protect_o}, 16'h0001);
        set_latch();
        cmd({sep_pkg::status_write_cmd, 8'h00, 16'h0000}, 16);
        chk({8'h00, status_o}, 16'h008E);
        wp_n_i = 1'b1;
        repeat (6) @(negedge clk_sys_i);
        chk({15'h0000, hw_protect_o}, 16'h0000);
        for (int k = 0; k < 6; k++) begin
            bp_val = {4'h0, tb_bp[k], 2'b00};
            set_latch();
            cmd({sep_pkg::status_write_cmd, bp_val, 16'h0000}, 16);
            wait_st(bp_val);
            set_latch();
            n = go_cnt;
            cmd({sep_pkg::array_write_cmd, tb_adr[k], 8'h5A}, 32);
            if (tb_ok[k]) begin
                chk(go_cnt[15:0], n[15:0] + 16'h0001);
                chk(last_addr, tb_adr[k]);
                wait_st(bp_val);
            end else begin
                chk(go_cnt[15:0], n[15:0]);
                chk({8'h00, status_o}, {8'h00, bp_val | 8'h02});
                cmd({sep_pkg::write_disable_cmd, 24'h00_0000}, 8);
            end
        end
        cmd({sep_pkg::array_read_cmd, 24'h12_3400}, 32);
        chk({8'h00, status_o}, 16'h000C);
        set_latch();
        chk({8'h00, status_o}, 16'h000E);
        // reset in mid-run clears the latch and the stored bits
        rst_i = 1'b1;
        repeat (3) @(negedge clk_sys_i);
        rst_i = 1'b0;
        repeat (4) @(negedge clk_sys_i);
        chk({8'h00, status_o}, 16'h0000);
        set_latch();
        chk({8'h00, status_o}, 16'h0002);
        print_verdict();
    end
endmodule : sep_cmd_protect_test
